// *** logic/port_pin_mux.sv ***
`timescale 1ns/1ns
module port_pin_mux
    import port_pin_mux_pkg::*;
(
    // Clock and pin reset
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              reset_pin_n,
    output logic                   system_reset,
    // Straps and programming enable
    input  wire logic              por_strap,
    input  wire logic              flash_write_mode_n,
    output logic                   por_enable,
    output logic                   flash_write_mode_n_active,
    // Register writes, one strobe per register
    input  wire logic [7:0]        write_data,
    input  wire logic              port0_data_we,
    input  wire logic              port1_data_we,
    input  wire logic              port2_data_we,
    input  wire logic              port3_data_we,
    input  wire logic              port0_direction_we,
    input  wire logic              port1_direction_we,
    input  wire logic              port2_direction_we,
    input  wire logic              port3_direction_we,
    // Stored register values and pin reads
    output logic [P0_W-1:0]        port0_direction,
    output logic [P1_W-1:0]        port1_direction,
    output logic [P2_W-1:0]        port2_direction,
    output logic [P3_W-1:0]        port3_direction,
    output logic [P0_W-1:0]        port0_data,
    output logic [P1_W-1:0]        port1_data,
    output logic [P2_W-1:0]        port2_data,
    output logic [P3_W-1:0]        port3_data,
    output logic [P0_W-1:0]        port0_read,
    output logic [P1_W-1:0]        port1_read,
    output logic [P2_W-1:0]        port2_read,
    output logic [P3_W-1:0]        port3_read,
    // Peripheral enables
    input  wire logic              spi_control_reg,
    input  wire logic              uart1_enable,
    input  wire logic              uart0_enable,
    input  wire logic              modulator_a_enable,
    input  wire logic              modulator_b_enable,
    input  wire logic [1:0]        interrupt_enable_reg,
    input  wire logic [1:0]        irq_edge_mode,
    input  wire logic              irq_clear_a,
    input  wire logic              irq_clear_b,
    input  wire logic [1:0]        rf_front_end_config,
    // Peripheral signals
    input  wire logic              spi_sck,
    input  wire logic              spi_mosi,
    output logic                   spi_miso,
    output logic                   flash_write_mode_n_sck,
    output logic                   flash_write_mode_n_si,
    input  wire logic              flash_write_mode_n_so,
    output logic                   uart1_receive_pin,
    input  wire logic              uart1_transmit_pin,
    output logic                   uart0_receive_pin,
    input  wire logic              uart0_transmit_pin,
    input  wire logic              modulator_out_a,
    input  wire logic              modulator_out_b,
    output logic                   ext_irq_a,
    output logic                   ext_irq_b,
    output analog_sel_t            analog_pin_select,
    // Pins; an enable of zero means the pin is driven
    input  wire logic [P0_W-1:0]   port0_in,
    input  wire logic [P1_W-1:0]   port1_in,
    input  wire logic [P2_W-1:0]   port2_in,
    input  wire logic [P3_W-1:0]   port3_in,
    output logic [P0_W-1:0]        port0_out,
    output logic [P1_W-1:0]        port1_out,
    output logic [P2_W-1:0]        port2_out,
    output logic [P3_W-1:0]        port3_out,
    output logic [P0_W-1:0]        port0_oe_n,
    output logic [P1_W-1:0]        port1_oe_n,
    output logic [P2_W-1:0]        port2_oe_n,
    output logic [P3_W-1:0]        port3_oe_n
);

    logic              rst_meta_reg;
    logic              rst_sync_reg;
    logic              spi_on;
    logic [1:0]        irq_pin;
    logic [1:0]        irq_prev_reg;
    logic [1:0]        irq_clear;
    logic [1:0]        irq_flag_reg;
    logic [1:0]        irq_flag_next;
    logic [P0_W-1:0]   p0_out_next;
    logic [P0_W-1:0]   p0_oe_next;
    logic [P2_W-1:0]   p2_out_next;
    logic [P2_W-1:0]   p2_oe_next;
    logic [P3_W-1:0]   p3_out_next;
    logic [P3_W-1:0]   p3_oe_next;

    // Request decode shared by both external interrupt inputs.
    function automatic logic irq_request(input logic enable,
                                         input logic edge_mode,
                                         input logic flag,
                                         input logic pin_level);
        return enable & (edge_mode ? flag : ~pin_level);
    endfunction

    // The pin reset is caught asynchronously and released on the clock,
    // so release never races the clock edge.
    always_ff @(posedge clock or negedge reset_pin_n) begin
        if (!reset_pin_n) begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= 1'b1;
        end else begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            system_reset <= 1'b1;
        end else begin
            system_reset <= rst_sync_reg;
        end
    end

    // Straps are sampled after reset, never loaded by the reset itself.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            por_enable  <= 1'b0;
            flash_write_mode_n_active <= 1'b0;
        end else begin
            por_enable  <= por_strap;
            flash_write_mode_n_active <= ~flash_write_mode_n;
        end
    end

    // Register writes; overrides never touch these, so software values
    // come back intact when a peripheral lets go.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port0_data      <= DATA_RESET[P0_W-1:0];
            port0_direction <= DIR_RESET[P0_W-1:0];
        end else begin
            if (port0_data_we) begin
                port0_data <= write_data[P0_W-1:0];
            end
            if (port0_direction_we) begin
                port0_direction <= write_data[P0_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port1_data      <= DATA_RESET[P1_W-1:0];
            port1_direction <= DIR_RESET[P1_W-1:0];
        end else begin
            if (port1_data_we) begin
                port1_data <= write_data[P1_W-1:0];
            end
            if (port1_direction_we) begin
                port1_direction <= write_data[P1_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port2_data      <= DATA_RESET[P2_W-1:0];
            port2_direction <= DIR_RESET[P2_W-1:0];
        end else begin
            if (port2_data_we) begin
                port2_data <= write_data[P2_W-1:0];
            end
            if (port2_direction_we) begin
                port2_direction <= write_data[P2_W-1:0];
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port3_data      <= DATA_RESET[P3_W-1:0];
            port3_direction <= DIR_RESET[P3_W-1:0];
        end else begin
            if (port3_data_we) begin
                port3_data <= write_data[P3_W-1:0];
            end
            if (port3_direction_we) begin
                port3_direction <= write_data[P3_W-1:0];
            end
        end
    end

    // Programming mode has priority over the software SPI master.
    assign spi_on = spi_control_reg & ~flash_write_mode_n_active;

    // Pin drive: direction bit 1 drives the data bit, 0 releases.
    always_comb begin
        p0_out_next = port0_data;
        p0_oe_next  = ~port0_direction;
        p2_out_next = port2_data;
        p2_oe_next  = ~port2_direction;
        p3_out_next = port3_data;
        p3_oe_next  = ~port3_direction;
        if (flash_write_mode_n_active) begin
            p0_out_next[SPI_MISO_BIT] = flash_write_mode_n_so;
            p0_oe_next[SPI_MISO_BIT]  = 1'b0;
            p0_oe_next[SPI_SCK_BIT]   = 1'b1;
            p0_oe_next[SPI_MOSI_BIT]  = 1'b1;
        end else if (spi_on) begin
            p0_out_next[SPI_SCK_BIT]  = spi_sck;
            p0_out_next[SPI_MOSI_BIT] = spi_mosi;
            p0_out_next[SPI_MISO_BIT] = 1'b0;
            p0_oe_next[SPI_MOSI_BIT]  = 1'b0;
            p0_oe_next[SPI_MISO_BIT]  = 1'b1;
        end
        if (uart1_enable) begin
            p2_out_next[U1_TX_BIT] = uart1_transmit_pin;
            p2_oe_next[U1_TX_BIT]  = 1'b0;
            p2_oe_next[U1_RX_BIT]  = 1'b1;
        end
        if (uart0_enable) begin
            p3_out_next[U0_TX_BIT] = uart0_transmit_pin;
            p3_oe_next[U0_TX_BIT]  = 1'b0;
            p3_oe_next[U0_RX_BIT]  = 1'b1;
        end
        if (modulator_a_enable) begin
            p3_out_next[MOD_A_BIT] = modulator_out_a;
            p3_oe_next[MOD_A_BIT]  = 1'b0;
        end
        if (modulator_b_enable) begin
            p3_out_next[MOD_B_BIT] = modulator_out_b;
            p3_oe_next[MOD_B_BIT]  = 1'b0;
        end
    end

    // Pads are fed from flops so an override change never glitches a pin.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port0_out  <= '0;
            port0_oe_n <= '1;
        end else begin
            port0_out  <= p0_out_next;
            port0_oe_n <= p0_oe_next;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port1_out  <= '0;
            port1_oe_n <= '1;
        end else begin
            port1_out  <= port1_data;
            port1_oe_n <= ~port1_direction;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port2_out  <= '0;
            port2_oe_n <= '1;
        end else begin
            port2_out  <= p2_out_next;
            port2_oe_n <= p2_oe_next;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port3_out  <= '0;
            port3_oe_n <= '1;
        end else begin
            port3_out  <= p3_out_next;
            port3_oe_n <= p3_oe_next;
        end
    end

    // Pin reads and peripheral inputs are registered copies of the pins.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port0_read        <= '0;
            port1_read        <= '0;
            port2_read        <= '0;
            port3_read        <= '0;
            spi_miso          <= 1'b0;
            flash_write_mode_n_sck          <= 1'b0;
            flash_write_mode_n_si           <= 1'b0;
            uart1_receive_pin <= 1'b1;
            uart0_receive_pin <= 1'b1;
        end else begin
            port0_read        <= port0_in;
            port1_read        <= port1_in;
            port2_read        <= port2_in;
            port3_read        <= port3_in;
            spi_miso          <= spi_on & port0_in[SPI_MISO_BIT];
            flash_write_mode_n_sck          <= flash_write_mode_n_active & port0_in[SPI_SCK_BIT];
            flash_write_mode_n_si           <= flash_write_mode_n_active & port0_in[SPI_MOSI_BIT];
            uart1_receive_pin <= ~uart1_enable | port2_in[U1_RX_BIT];
            uart0_receive_pin <= ~uart0_enable | port3_in[U0_RX_BIT];
        end
    end

    // External interrupts: low level, or a falling edge caught in a flag.
    // An edge in the clearing cycle wins, so no event is lost.
    assign irq_pin   = {port3_in[IRQ_B_BIT], port3_in[IRQ_A_BIT]};
    assign irq_clear = {irq_clear_b, irq_clear_a};

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            irq_flag_next[i] = irq_flag_reg[i];
            if (irq_clear[i]) begin
                irq_flag_next[i] = 1'b0;
            end
            if (irq_prev_reg[i] & ~irq_pin[i]) begin
                irq_flag_next[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            irq_prev_reg <= 2'h3;
            irq_flag_reg <= 2'h0;
            ext_irq_a    <= 1'b0;
            ext_irq_b    <= 1'b0;
        end else begin
            irq_prev_reg <= irq_pin;
            irq_flag_reg <= irq_flag_next;
            ext_irq_a    <= irq_request(interrupt_enable_reg[0],
                                        irq_edge_mode[0], irq_flag_next[0],
                                        irq_pin[0]);
            ext_irq_b    <= irq_request(interrupt_enable_reg[1],
                                        irq_edge_mode[1], irq_flag_next[1],
                                        irq_pin[1]);
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            analog_pin_select <= ANA_ADC;
        end else begin
            unique case (rf_front_end_config)
                2'h1:    analog_pin_select <= ANA_RSSI;
                2'h2:    analog_pin_select <= ANA_IF;
                default: analog_pin_select <= ANA_ADC;
            endcase
        end
    end

endmodule // port_pin_mux

// *** logic/port_pin_mux_pkg.sv ***
package port_pin_mux_pkg;
    localparam int P0_W = 4;
    localparam int P1_W = 8;
    localparam int P2_W = 8;
    localparam int P3_W = 6;
    localparam int SPI_SCK_BIT  = 0;
    localparam int SPI_MOSI_BIT = 1;
    localparam int SPI_MISO_BIT = 2;
    localparam int U1_RX_BIT = 0;
    localparam int U1_TX_BIT = 1;
    localparam int U0_RX_BIT = 0;
    localparam int U0_TX_BIT = 1;
    localparam int IRQ_A_BIT = 2;
    localparam int IRQ_B_BIT = 3;
    localparam int MOD_A_BIT = 4;
    localparam int MOD_B_BIT = 5;
    localparam logic [7:0] DATA_RESET = 8'hff;
    localparam logic [7:0] DIR_RESET  = 8'h00;
    typedef enum logic [1:0] {
        ANA_ADC  = 2'h0,
        ANA_RSSI = 2'h1,
        ANA_IF   = 2'h2
    } analog_sel_t;
endpackage

// *** bench/port_pin_mux_assertions.sv ***
`timescale 1ns/1ns
module port_pin_mux_assertions
    import port_pin_mux_pkg::*;
(
    // Clock and resets
    input wire logic            clock,
    input wire logic            reset,
    input wire logic            reset_pin_n,
    input wire logic            system_reset,
    input wire logic            por_strap,
    input wire logic            por_enable,
    // Programming and SPI
    input wire logic            flash_write_mode_n,
    input wire logic            flash_write_mode_n_active,
    input wire logic            flash_write_mode_n_so,
    input wire logic            spi_control_reg,
    input wire logic            spi_mosi,
    input wire logic [P0_W-1:0] port0_out,
    input wire logic [P0_W-1:0] port0_oe_n,
    // Port 1
    input wire logic [P1_W-1:0] port1_direction,
    input wire logic [P1_W-1:0] port1_data,
    input wire logic [P1_W-1:0] port1_out,
    input wire logic [P1_W-1:0] port1_oe_n,
    // Port 3 functions
    input wire logic [1:0]      interrupt_enable_reg,
    input wire logic [1:0]      irq_edge_mode,
    input wire logic            ext_irq_a,
    input wire logic            uart0_enable,
    input wire logic            uart0_transmit_pin,
    input wire logic            uart0_receive_pin,
    input wire logic            modulator_a_enable,
    input wire logic            modulator_out_a,
    input wire logic [P3_W-1:0] port3_in,
    input wire logic [P3_W-1:0] port3_out,
    input wire logic [P3_W-1:0] port3_oe_n
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    sequence spi_s;
        (spi_control_reg && flash_write_mode_n && !flash_write_mode_n_active) [*2];
    endsequence
    sequence flash_write_mode_n_s;
        (!flash_write_mode_n) [*3];
    endsequence
    spi_pins_a: assert property (spi_s |->
        !port0_oe_n[1] && port0_oe_n[2] && port0_out[1] == $past(spi_mosi))
        else $error("SPI pin takeover wrong");
    flash_write_mode_n_pins_a: assert property (flash_write_mode_n_s |->
        port0_oe_n[2:0] == 3'h3 && port0_out[2] == $past(flash_write_mode_n_so))
        else $error("programming pins wrong");
    pin_reset_a: assert property (!reset_pin_n |=> system_reset)
        else $error("reset pin ignored");
    reset_done_a: assert property (reset_pin_n [*6] |->
        !system_reset)
        else $error("reset not released");
    por_copy_a: assert property (1'b1 |=>
        por_enable == $past(por_strap))
        else $error("strap not followed");
    irq_level_a: assert property (interrupt_enable_reg[0] &&
        !irq_edge_mode[0] |=> ext_irq_a == !$past(port3_in[IRQ_A_BIT]))
        else $error("level interrupt wrong");
    irq_edge_a: assert property (interrupt_enable_reg[0] &&
        irq_edge_mode[0] && $fell(port3_in[IRQ_A_BIT]) |=> ext_irq_a)
        else $error("edge interrupt missed");
    irq_mask_a: assert property (!interrupt_enable_reg[0] |=> !ext_irq_a)
        else $error("masked interrupt raised");
    mod_drive_a: assert property (modulator_a_enable [*2] |->
        !port3_oe_n[MOD_A_BIT] &&
        port3_out[MOD_A_BIT] == $past(modulator_out_a))
        else $error("modulator pin wrong");
    uart_pins_a: assert property (uart0_enable [*2] |->
        port3_oe_n[1:0] == 2'h1 && port3_out[1] == $past(uart0_transmit_pin)
        && uart0_receive_pin == $past(port3_in[U0_RX_BIT]))
        else $error("uart pins wrong");
    port_drive_a: assert property (!$past(reset) |->
        port1_oe_n == ~$past(port1_direction) &&
        ((port1_out ^ $past(port1_data)) & ~port1_oe_n) == '0)
        else $error("port 1 drive wrong");
endmodule // port_pin_mux_assertions

bind port_pin_mux port_pin_mux_assertions u_port_pin_mux_assertions (
    .clock, .reset, .reset_pin_n, .system_reset, .por_strap, .por_enable,
    .flash_write_mode_n, .flash_write_mode_n_active, .flash_write_mode_n_so, .spi_control_reg, .spi_mosi,
    .port0_out, .port0_oe_n, .port1_direction, .port1_data, .port1_out,
    .port1_oe_n, .interrupt_enable_reg, .irq_edge_mode, .ext_irq_a,
    .uart0_enable, .uart0_transmit_pin, .uart0_receive_pin,
    .modulator_a_enable, .modulator_out_a, .port3_in, .port3_out, .port3_oe_n
);

// *** bench/port_pin_mux_board.sv ***
`timescale 1ns/1ns
module port_pin_mux_board #(
    parameter int W = 8
) (
    // Pin side
    input  wire logic [W-1:0] out,
    input  wire logic [W-1:0] oe_n,
    input  wire logic [W-1:0] ext,
    output logic      [W-1:0] level
);
    // A released pin shows only what the board drives, never a stale value.
    assign level = (out & ~oe_n) | (ext & oe_n);
endmodule // port_pin_mux_board

// *** bench/port_pin_mux_tb.sv ***
`timescale 1ns/1ns
`define CK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
    $display("[ERR] %0t mismatch %h", $time, (a)); end end
module port_pin_mux_tb;
    import port_pin_mux_pkg::*;
    localparam logic [3:0][7:0] M = {8'h3f, 8'hff, 8'hff, 8'h0f};
    logic       clock, reset, rst_drive, por_strap, flash_write_mode_n;
    logic       spi_control_reg, spi_sck, spi_mosi, flash_write_mode_n_so;
    logic       uart1_enable, uart0_enable, uart1_transmit_pin;
    logic       uart0_transmit_pin, irq_clear_a, irq_clear_b;
    logic       modulator_a_enable, modulator_b_enable;
    logic       modulator_out_a, modulator_out_b;
    logic [1:0] interrupt_enable_reg, irq_edge_mode, rf_front_end_config;
    logic [7:0] write_data, v, d;
    logic [3:0] dwe, rwe;
    logic       system_reset, por_enable, flash_write_mode_n_active, spi_miso, flash_write_mode_n_sck;
    logic       flash_write_mode_n_si, uart1_receive_pin, uart0_receive_pin;
    logic       ext_irq_a, ext_irq_b;
    analog_sel_t        analog_pin_select;
    logic [3:0][7:0]    ext;
    wire  [3:0][7:0]    pin, oe, out, rd, dr, dt;
    wire                reset_pin_n;
    int                 p, compares = 0, fail_count = 0;
    // The reset pin is the inverse of rst_drive: high whenever rst_drive is low.
    assign reset_pin_n = !rst_drive;
    // Bits above each port's width are tied off so nothing reads a float.
    assign {out[0][7:4], oe[0][7:4], dr[0][7:4], dt[0][7:4], rd[0][7:4]} = '0;
    assign {out[3][7:6], oe[3][7:6], dr[3][7:6], dt[3][7:6], rd[3][7:6]} = '0;
    port_pin_mux u_port_pin_mux (
        .clock, .reset, .reset_pin_n, .system_reset, .por_strap,
        .flash_write_mode_n, .por_enable, .flash_write_mode_n_active, .write_data,
        .port0_data_we(dwe[0]), .port1_data_we(dwe[1]),
        .port2_data_we(dwe[2]), .port3_data_we(dwe[3]),
        .port0_direction_we(rwe[0]), .port1_direction_we(rwe[1]),
        .port2_direction_we(rwe[2]), .port3_direction_we(rwe[3]),
        .port0_direction(dr[0][3:0]), .port1_direction(dr[1]),
        .port2_direction(dr[2]), .port3_direction(dr[3][5:0]),
        .port0_data(dt[0][3:0]), .port1_data(dt[1]),
        .port2_data(dt[2]), .port3_data(dt[3][5:0]),
        .port0_read(rd[0][3:0]), .port1_read(rd[1]),
        .port2_read(rd[2]), .port3_read(rd[3][5:0]),
        .spi_control_reg, .uart1_enable, .uart0_enable, .modulator_a_enable,
        .modulator_b_enable, .interrupt_enable_reg, .irq_edge_mode,
        .irq_clear_a, .irq_clear_b, .rf_front_end_config, .spi_sck,
        .spi_mosi, .spi_miso, .flash_write_mode_n_sck, .flash_write_mode_n_si, .flash_write_mode_n_so,
        .uart1_receive_pin, .uart1_transmit_pin, .uart0_receive_pin,
        .uart0_transmit_pin, .modulator_out_a, .modulator_out_b,
        .ext_irq_a, .ext_irq_b, .analog_pin_select,
        .port0_in(pin[0][3:0]), .port1_in(pin[1]), .port2_in(pin[2]),
        .port3_in(pin[3][5:0]), .port0_out(out[0][3:0]), .port1_out(out[1]),
        .port2_out(out[2]), .port3_out(out[3][5:0]),
        .port0_oe_n(oe[0][3:0]), .port1_oe_n(oe[1]), .port2_oe_n(oe[2]),
        .port3_oe_n(oe[3][5:0])
    );
    for (genvar g = 0; g < 4; g++) begin : g_pin
        port_pin_mux_board #(.W(8)) u_port_pin_mux_board (
            .out(out[g]), .oe_n(oe[g]), .ext(ext[g]), .level(pin[g]));
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic ticks(input int n);
        repeat (n) @(negedge clock);
    endtask
    task automatic wr(input int q, input bit dir, input logic [7:0] val);
        write_data = val;
        if (dir) rwe[q] = 1'b1;
        else dwe[q] = 1'b1;
        ticks(1);
        {rwe, dwe} = 8'h00;
        ticks(1);
    endtask
    task automatic give_verdict();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h010f7c4a));
        {reset, rst_drive, flash_write_mode_n} = 3'h5;
        {por_strap, spi_sck, spi_mosi, flash_write_mode_n_so} = 4'($urandom);
        {uart1_transmit_pin, uart0_transmit_pin} = 2'($urandom);
        {modulator_out_a, modulator_out_b} = 2'($urandom);
        {spi_control_reg, uart1_enable, uart0_enable} = 3'h0;
        {modulator_a_enable, modulator_b_enable} = 2'h0;
        {irq_clear_a, irq_clear_b} = 2'h0;
        {interrupt_enable_reg, irq_edge_mode, rf_front_end_config} = 6'h00;
        {write_data, dwe, rwe} = 16'h0000;
        ext = $urandom;
        ticks(3);
        reset = 1'b0;
        for (int i = 0; i < 4; i++) begin
            `CK(dt[i] & M[i], DATA_RESET & M[i])
            `CK(dr[i] & M[i], DIR_RESET & M[i])
        end
        ticks(1);
        `CK(por_enable, por_strap)
        for (int i = 0; i < 12; i++) begin
            p = i % 4;
            v = (i < 4) ? 8'hff : (i < 8) ? 8'h00 : 8'($urandom);
            d = 8'($urandom);
            wr(p, 1'b1, v);
            wr(p, 1'b0, d);
            ext[p] = 8'($urandom);
            ticks(2);
            `CK(dr[p] & M[p], v & M[p])
            `CK(dt[p] & M[p], d & M[p])
            `CK(oe[p] & M[p], ~v & M[p])
            `CK(out[p] & v & M[p], d & v & M[p])
            `CK(rd[p] & M[p], ((v & d) | (~v & ext[p])) & M[p])
        end
        wr(0, 1'b1, 8'h01);
        wr(0, 1'b0, 8'h02);
        {spi_sck, spi_mosi} = 2'h2;
        spi_control_reg = 1'b1;
        ticks(2);
        `CK(oe[0][3:0], 4'hc)
        `CK(out[0][1:0], {spi_mosi, spi_sck})
        `CK(spi_miso, ext[0][2])
        spi_control_reg = 1'b0;
        ticks(2);
        `CK(oe[0][3:0], 4'he)
        `CK(out[0][0], 1'b0)
        flash_write_mode_n_so = 1'b1;
        {spi_control_reg, flash_write_mode_n} = 2'h2;
        ticks(3);
        `CK(oe[0][2:0], 3'h3)
        `CK(out[0][2], flash_write_mode_n_so)
        `CK({flash_write_mode_n_si, flash_write_mode_n_sck}, ext[0][1:0])
        `CK(flash_write_mode_n_active, 1'b1)
        {spi_control_reg, flash_write_mode_n} = 2'h1;
        wr(3, 1'b1, 8'h00);
        wr(3, 1'b0, 8'h00);
        wr(2, 1'b0, 8'h00);
        {uart1_transmit_pin, uart0_transmit_pin} = 2'h3;
        {modulator_out_a, modulator_out_b} = 2'h3;
        {ext[2][0], ext[3][0]} = 2'h0;
        {uart1_enable, uart0_enable} = 2'h3;
        {modulator_a_enable, modulator_b_enable} = 2'h3;
        ticks(2);
        `CK({oe[2][1:0], oe[3][1:0]}, 4'h5)
        `CK({out[2][1], out[3][1]}, 2'h3)
        `CK({uart1_receive_pin, uart0_receive_pin}, 2'h0)
        `CK(oe[3][5:4], 2'h0)
        `CK(out[3][5:4], 2'h3)
        {uart1_enable, uart0_enable} = 2'h0;
        {modulator_a_enable, modulator_b_enable} = 2'h0;
        ticks(2);
        `CK(oe[3][5:0], 6'h3f)
        interrupt_enable_reg = 2'h3;
        ext[3][3:2] = 2'h1;
        ticks(2);
        `CK({ext_irq_b, ext_irq_a}, 2'h2)
        interrupt_enable_reg = 2'h0;
        ticks(2);
        `CK({ext_irq_b, ext_irq_a}, 2'h0)
        {irq_edge_mode, interrupt_enable_reg} = 4'hd;
        {irq_clear_a, irq_clear_b} = 2'h3;
        ticks(1);
        {irq_clear_a, irq_clear_b} = 2'h0;
        ticks(1);
        `CK(ext_irq_a, 1'b0)
        ext[3][2] = 1'b0;
        ticks(2);
        `CK(ext_irq_a, 1'b1)
        ext[3][2] = 1'b1;
        ticks(2);
        `CK(ext_irq_a, 1'b1)
        {irq_clear_a, irq_clear_b} = 2'h3;
        ticks(1);
        {irq_clear_a, irq_clear_b} = 2'h0;
        ticks(1);
        `CK(ext_irq_a, 1'b0)
        ext[3][2] = 1'b0;
        irq_clear_a = 1'b1;
        ticks(1);
        irq_clear_a = 1'b0;
        ext[3][2] = 1'b1;
        ticks(2);
        `CK(ext_irq_a, 1'b1)
        irq_clear_a = 1'b1;
        ticks(1);
        irq_clear_a = 1'b0;
        ticks(1);
        `CK(ext_irq_a, 1'b0)
        rst_drive = 1'b1;
        ticks(2);
        `CK(system_reset, 1'b1)
        rst_drive = 1'b0;
        ticks(6);
        `CK(system_reset, 1'b0)
        for (int k = 0; k < 4; k++) begin
            rf_front_end_config = 2'(k);
            ticks(2);
            `CK(analog_pin_select, (k == 3) ? ANA_ADC : analog_sel_t'(k))
        end
        reset = 1'b1;
        ticks(1);
        `CK(oe[1], 8'hff)
        reset = 1'b0;
        ticks(8);
        give_verdict();
    end
endmodule // port_pin_mux_tb
